// ### core/swt_wakeup_timers.sv
// Two slow-clock wakeup timers with RC calibration counter and APB slave
//
// Behaviour
// - Two independent wakeup timers, each a 35-bit down-counter.
// - Timers tick on the selected slow clock: RC, crystal or external input.
// - Timers freeze in deep sleep; they may count during ordinary sleep.
// - A software bit stops the timers while in ordinary sleep.
// - Reaching zero raises interrupt if enabled, wakeup event if enabled and asleep.
// - A timer wakeup event can end the sleep period.
// - After zero the counter keeps decrementing until software stops it.
// - Start loads the programmed count and decrements on each slow tick.
// - Stop holds the counter value at any time; a tick to zero in the stop cycle still raises flags.
// - Status shows running and expired per timer, even when masked.
// - Reading the status clears the expired flags that the read returned.
// - Reference counter runs on the system clock only while awake.
// - In calibration timer 0 counts down while the reference counts up.
// - Timer 0 reaching zero stops the reference; its count is readable.
// - Nominal RC over twenty periods gives the nominal reference count.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module swt_wakeup_timers #(
  parameter int CNT_W = swt_pkg::CNT_W_DEF,
  parameter int REF_W = swt_pkg::REF_W_DEF
) (
  input  wire logic                      core_clk,
  input  wire logic                      rstn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [swt_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic                      slow_rc,
  input  wire logic                      slow_xtal,
  input  wire logic                      slow_ext,
  input  wire logic                      sleep_mode,
  input  wire logic                      deep_sleep,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic                           irq,
  output logic                           wake_event
);
  localparam int HI_W = CNT_W - 32;
  // Count registers of timer 1 sit one pair above those of timer 0
  localparam logic [7:0] T_STRIDE = swt_pkg::OFF_T1_LO - swt_pkg::OFF_T0_LO;

  if (CNT_W <= 32 || CNT_W > 64) begin : g_bad_cnt
    $error("CNT_W must lie in 33..64");
  end
  if (REF_W < 1 || REF_W > 32) begin : g_bad_ref
    $error("REF_W must lie in 1..32");
  end
  // Status and command fields hold exactly two timers
  if (swt_pkg::N_TMR != 2) begin : g_bad_tmr
    $error("N_TMR must be 2");
  end

  function automatic logic [CNT_W-1:0] dec_cnt(input logic [CNT_W-1:0] v);
    dec_cnt = v - {{(CNT_W-1){1'b0}}, 1'b1};
  endfunction

  function automatic logic [31:0] lo_word(input logic [CNT_W-1:0] v);
    lo_word = v[31:0];
  endfunction

  function automatic logic [31:0] hi_word(input logic [CNT_W-1:0] v);
    hi_word = {{(64-CNT_W){1'b0}}, v[CNT_W-1:32]};
  endfunction

  logic [1:0]                    clk_sel;
  logic                          sleep_hold;
  logic [CNT_W-1:0]              load_val [swt_pkg::N_TMR];
  logic [CNT_W-1:0]              cnt      [swt_pkg::N_TMR];
  logic [swt_pkg::N_TMR-1:0]     run;
  logic [swt_pkg::N_TMR-1:0]     expired;
  logic [swt_pkg::N_TMR-1:0]     cap_exp;
  logic [swt_pkg::IRQ_W-1:0]     int_stat;
  logic [swt_pkg::IRQ_W-1:0]     int_mask;
  logic                          cal_active;
  logic [REF_W-1:0]              ref_cnt;
  logic                          slow_prev;
  logic                          slow_sel;
  logic                          slow_tick;
  logic                          count_en;
  logic [swt_pkg::N_TMR-1:0]     zero_hit;
  logic                          acc;
  logic                          wr;
  logic                          rd;
  logic                          cmd_wr;
  logic                          cal_go;
  logic [swt_pkg::N_TMR-1:0]     start_cmd;
  logic [swt_pkg::N_TMR-1:0]     stop_cmd;
  logic [31:0]                   next_rdata;
  logic                          next_err;

  // Slow clock source and its rising edge as a one-cycle enable
  always_comb begin
    case (clk_sel)
      swt_pkg::SEL_RC:   slow_sel = slow_rc;
      swt_pkg::SEL_XTAL: slow_sel = slow_xtal;
      swt_pkg::SEL_EXT:  slow_sel = slow_ext;
      default:           slow_sel = slow_rc;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      slow_prev <= 1'b0;
    end else begin
      slow_prev <= slow_sel;
    end
  end

  assign slow_tick = slow_sel & ~slow_prev;
  // Frozen in deep sleep, optionally held in ordinary sleep
  assign count_en  = slow_tick & ~deep_sleep
                   & ~(sleep_mode & sleep_hold);

  // APB decode; one wait-free access phase, data prepared in setup
  assign acc    = psel & penable & pready;
  assign wr     = acc & pwrite;
  assign rd     = acc & ~pwrite;
  assign cmd_wr = wr & (paddr == swt_pkg::OFF_CMD);
  assign cal_go = cmd_wr & pwdata[swt_pkg::CMD_CAL];

  always_comb begin
    for (int i = 0; i < swt_pkg::N_TMR; i++) begin
      stop_cmd[i]  = cmd_wr & pwdata[swt_pkg::CMD_STOP_LO + i];
      start_cmd[i] = cmd_wr & pwdata[swt_pkg::CMD_START_LO + i];
    end
    start_cmd[0] = start_cmd[0] | cal_go;
  end

  always_comb begin
    for (int i = 0; i < swt_pkg::N_TMR; i++) begin
      zero_hit[i] = run[i] & count_en
                  & (cnt[i] == {{(CNT_W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & ~penable;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    case (paddr)
      swt_pkg::OFF_CTRL: begin
        next_rdata[swt_pkg::CTRL_HOLD] = sleep_hold;
        next_rdata[swt_pkg::CTRL_SEL_LO +: 2] = clk_sel;
      end
      swt_pkg::OFF_CMD: next_rdata = 32'h0000_0000;
      swt_pkg::OFF_STATUS: begin
        next_rdata[swt_pkg::ST_RUN_LO +: 2] = run;
        next_rdata[swt_pkg::ST_EXP_LO +: 2] = expired;
      end
      // Live count, so latency after zero can be measured
      swt_pkg::OFF_T0_LO:    next_rdata = lo_word(cnt[0]);
      swt_pkg::OFF_T0_HI:    next_rdata = hi_word(cnt[0]);
      swt_pkg::OFF_T1_LO:    next_rdata = lo_word(cnt[1]);
      swt_pkg::OFF_T1_HI:    next_rdata = hi_word(cnt[1]);
      swt_pkg::OFF_CAL_REF:  next_rdata[REF_W-1:0] = ref_cnt;
      swt_pkg::OFF_INT_STAT: next_rdata[swt_pkg::IRQ_W-1:0] = int_stat;
      swt_pkg::OFF_INT_MASK: next_rdata[swt_pkg::IRQ_W-1:0] = int_mask;
      default:               next_err = 1'b1;
    endcase
  end

  // Expired bits are snapshotted with the read data, so a flag that
  // rises after the snapshot survives the clearing read
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      cap_exp <= '0;
    end else if (psel && !penable) begin
      prdata  <= next_rdata;
      pslverr <= next_err;
      cap_exp <= (paddr == swt_pkg::OFF_STATUS) ? expired : '0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sleep_hold <= 1'b0;
      clk_sel    <= swt_pkg::SEL_RST;
      int_mask   <= swt_pkg::MASK_RST;
    end else if (wr && paddr == swt_pkg::OFF_CTRL) begin
      sleep_hold <= pwdata[swt_pkg::CTRL_HOLD];
      clk_sel    <= pwdata[swt_pkg::CTRL_SEL_LO +: 2];
    end else if (wr && paddr == swt_pkg::OFF_INT_MASK) begin
      int_mask   <= pwdata[swt_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < swt_pkg::N_TMR; i++) begin
        load_val[i] <= '0;
      end
    end else if (wr) begin
      for (int i = 0; i < swt_pkg::N_TMR; i++) begin
        if (paddr == swt_pkg::OFF_T0_LO + T_STRIDE * 8'(i)) begin
          load_val[i][31:0] <= pwdata;
        end
        if (paddr == swt_pkg::OFF_T0_HI + T_STRIDE * 8'(i)) begin
          load_val[i][CNT_W-1:32] <= pwdata[HI_W-1:0];
        end
      end
    end
  end

  // Stop wins over start in the same write
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < swt_pkg::N_TMR; i++) begin
        cnt[i] <= '0;
        run[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < swt_pkg::N_TMR; i++) begin
        if (stop_cmd[i]) begin
          run[i] <= 1'b0;
        end else if (start_cmd[i]) begin
          cnt[i] <= load_val[i];
          run[i] <= 1'b1;
        end else if (run[i] && count_en) begin
          cnt[i] <= dec_cnt(cnt[i]);
        end
      end
    end
  end

  // Set wins over the clearing read
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      expired <= '0;
    end else begin
      expired <= (expired & ~(rd ? cap_exp : '0)) | zero_hit;
    end
  end

  // Reference counts system clocks in the timer 0 window while awake;
  // the nominal count assumes a 16 MHz system clock
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cal_active <= 1'b0;
      ref_cnt    <= '0;
    end else if (cal_go && !stop_cmd[0]) begin
      cal_active <= 1'b1;
      ref_cnt    <= '0;
    end else if (cal_active) begin
      if (zero_hit[0] || stop_cmd[0]) begin
        cal_active <= 1'b0;
      end
      if (!sleep_mode && !deep_sleep) begin
        ref_cnt <= ref_cnt + REF_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      int_stat <= '0;
    end else begin
      int_stat <= (int_stat & ~((wr && paddr == swt_pkg::OFF_INT_STAT)
                  ? pwdata[swt_pkg::IRQ_W-1:0] : '0))
                | {zero_hit[0] & cal_active, zero_hit};
    end
  end

  // Wakeup needs the timer interrupt enabled, as software is told to do
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq        <= 1'b0;
      wake_event <= 1'b0;
    end else begin
      irq        <= |(int_stat & int_mask);
      wake_event <= (sleep_mode | deep_sleep)
                  & |(zero_hit & int_mask[swt_pkg::N_TMR-1:0]);
    end
  end

  // Every check runs on the system clock
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  chk_zero_sets_stat: assert property (
    zero_hit[0] |=> int_stat[0] && expired[0])
    else $error("timer 0 zero did not set status");
  chk_deep_freeze: assert property (
    deep_sleep && !cmd_wr |=> $stable(cnt[0]))
    else $error("timer 0 moved in deep sleep");
  chk_sleep_hold: assert property (
    sleep_mode && sleep_hold && !cmd_wr |=> $stable(cnt[0]))
    else $error("timer 0 moved while held in sleep");
  chk_stop_holds: assert property (
    stop_cmd[1] |=> !run[1] ##1 $stable(cnt[1]) && !zero_hit[1])
    else $error("stopped timer 1 changed");
  chk_dec_step: assert property (
    run[0] && count_en && !cmd_wr |=> cnt[0] == dec_cnt($past(cnt[0])))
    else $error("timer 0 did not decrement by one");
  chk_start_load: assert property (
    start_cmd[1] && !stop_cmd[1] |=> run[1] && cnt[1] == $past(load_val[1]))
    else $error("timer 1 start did not load");
  chk_read_clears: assert property (
    rd && cap_exp[0] && !zero_hit[0] |=> !expired[0])
    else $error("status read left expired flag");
  chk_cal_clear: assert property (
    cal_go && !stop_cmd[0] |=> ref_cnt == '0 && cal_active)
    else $error("calibration start did not clear reference");
  chk_cal_stop: assert property (
    cal_active && zero_hit[0] && !cal_go |=> !cal_active ##1 $stable(ref_cnt))
    else $error("reference did not stop at timer 0 zero");
  chk_ref_counts: assert property (
    cal_active && !cal_go && !sleep_mode && !deep_sleep
      |=> ref_cnt == $past(ref_cnt) + REF_W'(1))
    else $error("reference missed a system clock");
  chk_ref_asleep: assert property (
    cal_active && !cal_go && (sleep_mode || deep_sleep) |=> $stable(ref_cnt))
    else $error("reference counted while asleep");
  chk_wake_pulse: assert property (
    sleep_mode && zero_hit[0] && int_mask[0] |=> wake_event)
    else $error("no wakeup event on timer 0 zero");
  chk_irq_level: assert property (
    |(int_stat & int_mask) |=> irq)
    else $error("interrupt not raised");

  cov_cal_done:   cover property (cal_active ##1 !cal_active && ref_cnt != '0);
  cov_wake:       cover property (wake_event);
  cov_read_clear: cover property (rd && cap_exp != '0);
  cov_irq:        cover property (!irq ##1 irq);
  cov_sleep_cal:  cover property (cal_active && sleep_mode && zero_hit[0]);
endmodule : swt_wakeup_timers
`default_nettype wire

// ### pkg/swt_pkg.sv
// Constants shared by the sleep wakeup timer block
`default_nettype none
package swt_pkg;
  localparam int          ADDR_W       = 8;
  localparam int          CNT_W_DEF    = 35;
  localparam int          REF_W_DEF    = 32;
  localparam int          N_TMR        = 2;
  // Register byte offsets
  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_CMD      = 8'h04;
  localparam logic [7:0]  OFF_STATUS   = 8'h08;
  localparam logic [7:0]  OFF_T0_LO    = 8'h0c;
  localparam logic [7:0]  OFF_T0_HI    = 8'h10;
  localparam logic [7:0]  OFF_T1_LO    = 8'h14;
  localparam logic [7:0]  OFF_T1_HI    = 8'h18;
  localparam logic [7:0]  OFF_CAL_REF  = 8'h1c;
  localparam logic [7:0]  OFF_INT_STAT = 8'h20;
  localparam logic [7:0]  OFF_INT_MASK = 8'h24;
  // Control register fields
  localparam int          CTRL_HOLD    = 0;
  localparam int          CTRL_SEL_LO  = 1;
  // Command register fields
  localparam int          CMD_START_LO = 0;
  localparam int          CMD_STOP_LO  = 2;
  localparam int          CMD_CAL      = 4;
  // Status register fields
  localparam int          ST_RUN_LO    = 0;
  localparam int          ST_EXP_LO    = 2;
  // Interrupt status bits
  localparam int          IRQ_CAL      = 2;
  localparam int          IRQ_W        = 3;
  // Slow clock source select
  localparam logic [1:0]  SEL_RC       = 2'h0;
  localparam logic [1:0]  SEL_XTAL     = 2'h1;
  localparam logic [1:0]  SEL_EXT      = 2'h2;
  // Reset values
  localparam logic [1:0]  SEL_RST      = 2'h0;
  localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;
  // Nominal calibration figures: slow periods and expected 16 MHz ticks
  localparam int          CAL_NOM_PER  = 20;
  localparam int          CAL_NOM_REF  = 10000;
endpackage : swt_pkg
`default_nettype wire

// ### test/swt_testbench.sv
// Self-checking bench for the sleep wakeup timer block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] q;
    logic        e;
  } swt_row_s;
  logic        core_clk   = 1'b0;
  logic        rstn       = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0;
  logic        slow_rc    = 1'b0;
  logic        slow_xtal  = 1'b0;
  logic        slow_ext   = 1'b0;
  logic        sleep_mode = 1'b0;
  logic        deep_sleep = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        wake_event;
  logic [31:0] rd;
  logic [31:0] keep;
  logic        er;
  int          fail_count = 0;
  int          cmp_count  = 0;
  int          ph         = 0;
  int          rc_per     = 20;
  int          wake_cnt   = 0;
  int          n;
  int          per [3]    = '{20, 16, 12};
  swt_row_s    rows [10]  = '{
    '{1'h0, swt_pkg::OFF_CTRL, 32'h0, 32'h0, 1'h0},
    '{1'h0, swt_pkg::OFF_INT_MASK, 32'h0, 32'h0, 1'h0},
    '{1'h0, swt_pkg::OFF_STATUS, 32'h0, 32'h0, 1'h0},
    '{1'h0, swt_pkg::OFF_CAL_REF, 32'h0, 32'h0, 1'h0},
    '{1'h1, swt_pkg::OFF_CTRL, 32'hffffffff, 32'h0, 1'h0},
    '{1'h0, swt_pkg::OFF_CTRL, 32'h0, 32'h7, 1'h0},
    '{1'h1, swt_pkg::OFF_INT_MASK, 32'hffffffff, 32'h0, 1'h0},
    '{1'h0, swt_pkg::OFF_INT_MASK, 32'h0, 32'h7, 1'h0},
    '{1'h0, 8'h40, 32'h0, 32'h0, 1'h1},
    '{1'h1, 8'h44, 32'h1, 32'h0, 1'h1}
  };

  always #5 core_clk = ~core_clk;

  // Slow clocks as synchronous levels, unrelated periods per source
  always @(posedge core_clk) begin
    ph        <= ph + 1;
    slow_rc   <= (ph % rc_per) < (rc_per / 2);
    slow_xtal <= (ph % 16) < 8;
    slow_ext  <= (ph % 12) < 6;
    if (wake_event === 1'b1) begin
      wake_cnt <= wake_cnt + 1;
    end
  end

  swt_wakeup_timers dut_u (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .slow_rc(slow_rc),
    .slow_xtal(slow_xtal), .slow_ext(slow_ext), .sleep_mode(sleep_mode),
    .deep_sleep(deep_sleep), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .wake_event(wake_event)
  );

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request held until pready is seen high; no wait-state count assumed
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 40) begin
      fail_count++;
      give_verdict();
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // Counts cycles until irq; a hang ends the run
  task automatic wait_irq(output int c);
    c = 0;
    while (irq !== 1'b1) begin
      @(posedge core_clk);
      c++;
      if (c > 3000) begin
        fail_count++;
        give_verdict();
      end
    end
  endtask

  task automatic in_range(input int v, input int lo, input int hi);
    cmp_count++;
    if (v < lo || v > hi) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
    end
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) check(rd, rows[i].q);
      check({31'h0, er}, {31'h0, rows[i].e});
    end
    apb(1'b1, swt_pkg::OFF_CTRL, 32'h0);
    // Interrupt enabled before the period is loaded
    apb(1'b1, swt_pkg::OFF_INT_MASK, 32'h1);
    apb(1'b1, swt_pkg::OFF_T0_LO, 32'h5);
    apb(1'b1, swt_pkg::OFF_T0_HI, 32'h0);
    apb(1'b1, swt_pkg::OFF_CMD, 32'h1);
    wait_irq(n);
    in_range(n, 80, 106);
    rchk(swt_pkg::OFF_STATUS, 32'h5);
    rchk(swt_pkg::OFF_STATUS, 32'h1);
    rchk(swt_pkg::OFF_INT_STAT, 32'h1);
    apb(1'b1, swt_pkg::OFF_INT_STAT, 32'h1);
    repeat (3) @(posedge core_clk);
    check({31'h0, irq}, 32'h0);
    // Let the next tick wrap the counter past zero
    repeat (rc_per) @(posedge core_clk);
    rchk(swt_pkg::OFF_T0_HI, 32'h7);
    apb(1'b1, swt_pkg::OFF_CMD, 32'h4);
    apb(1'b0, swt_pkg::OFF_T0_LO, 32'h0);
    keep = rd;
    repeat (60) @(posedge core_clk);
    rchk(swt_pkg::OFF_T0_LO, keep);
    rchk(swt_pkg::OFF_STATUS, 32'h0);
    rchk(swt_pkg::OFF_INT_STAT, 32'h0);
    // Deep sleep freezes; hold bit freezes ordinary sleep
    apb(1'b1, swt_pkg::OFF_T0_LO, 32'h3);
    apb(1'b1, swt_pkg::OFF_CMD, 32'h1);
    deep_sleep <= 1'b1;
    apb(1'b0, swt_pkg::OFF_T0_LO, 32'h0);
    keep = rd;
    repeat (150) @(posedge core_clk);
    rchk(swt_pkg::OFF_T0_LO, keep);
    apb(1'b1, swt_pkg::OFF_CTRL, 32'h1);
    deep_sleep <= 1'b0;
    sleep_mode <= 1'b1;
    repeat (150) @(posedge core_clk);
    rchk(swt_pkg::OFF_T0_LO, keep);
    rchk(swt_pkg::OFF_INT_STAT, 32'h0);
    apb(1'b1, swt_pkg::OFF_CTRL, 32'h0);
    wait_irq(n);
    repeat (3) @(posedge core_clk);
    check(wake_cnt, 32'h1);
    sleep_mode <= 1'b0;
    apb(1'b1, swt_pkg::OFF_CMD, 32'h4);
    apb(1'b1, swt_pkg::OFF_INT_STAT, 32'h7);
    // Each source, timer 1; ranges do not overlap between periods
    apb(1'b1, swt_pkg::OFF_INT_MASK, 32'h2);
    apb(1'b1, swt_pkg::OFF_T1_LO, 32'h8);
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, swt_pkg::OFF_CTRL, s << 1);
      apb(1'b1, swt_pkg::OFF_CMD, 32'h2);
      wait_irq(n);
      in_range(n, 7 * per[s], 8 * per[s] + 6);
      apb(1'b1, swt_pkg::OFF_CMD, 32'h8);
      apb(1'b1, swt_pkg::OFF_INT_STAT, 32'h7);
    end
    // Calibration: nominal then a faster RC clock
    apb(1'b1, swt_pkg::OFF_CTRL, 32'h0);
    apb(1'b1, swt_pkg::OFF_INT_MASK, 32'h4);
    apb(1'b1, swt_pkg::OFF_T0_LO, 32'd20);
    for (int c = 0; c < 2; c++) begin
      apb(1'b1, swt_pkg::OFF_CMD, 32'h10);
      wait_irq(n);
      apb(1'b0, swt_pkg::OFF_CAL_REF, 32'h0);
      in_range(rd, 19 * rc_per, 20 * rc_per + 6);
      keep = rd;
      repeat (50) @(posedge core_clk);
      rchk(swt_pkg::OFF_CAL_REF, keep);
      apb(1'b1, swt_pkg::OFF_CMD, 32'h4);
      apb(1'b1, swt_pkg::OFF_INT_STAT, 32'h7);
      rc_per = 16;
    end
    // Asleep the reference holds while timer 0 still ends the window
    sleep_mode <= 1'b1;
    apb(1'b1, swt_pkg::OFF_CMD, 32'h10);
    wait_irq(n);
    apb(1'b0, swt_pkg::OFF_CAL_REF, 32'h0);
    check(rd, 32'h0);
    sleep_mode <= 1'b0;
    apb(1'b1, swt_pkg::OFF_CMD, 32'h4);
    apb(1'b1, swt_pkg::OFF_INT_STAT, 32'h7);
    // Reset in mid-run clears a running timer
    apb(1'b1, swt_pkg::OFF_CMD, 32'h2);
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    rchk(swt_pkg::OFF_STATUS, 32'h0);
    rchk(swt_pkg::OFF_INT_MASK, 32'h0);
    check({31'h0, irq}, 32'h0);
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
